/* File: pmc_apb_port.sv */
// Purpose: APB slave front end; answers every access in two access cycles
// Assumes: Master holds request until pready
// Notes:   Unmapped index gives pslverr and zero read data
`timescale 1ns/10ps
module pmc_apb_port
  import pmc_pkg::*;
(
  input  wire logic                            clk_sys_i,
  input  wire logic                            reset_i,
  input  wire logic                            psel_i,
  input  wire logic                            penable_i,
  input  wire logic                            pwrite_i,
  input  wire logic [pmc_pkg::PMC_ADDR_W-1:0]  paddr_i,
  input  wire logic [pmc_pkg::PMC_DATA_W-1:0]  pwdata_i,
  input  wire logic [3:0]                      pstrb_i,
  output logic      [pmc_pkg::PMC_DATA_W-1:0]  prdata_o,
  output logic                                 pready_o,
  output logic                                 pslverr_o,
  pmc_regbus_if.front                          rb
);
  import pmc_pkg::*;

  typedef struct packed {
    pmc_state_t       st;
    logic             ready;
    logic             slverr;
    logic [31:0]      rdata;
  } pmc_apb_state_t;

  pmc_apb_state_t cur_ff;
  pmc_apb_state_t nxt_cur;

  // ==========================================================================
  // Request fields
  assign rb.index = paddr_i[PMC_ADDR_W-1:2];
  assign rb.wdata = pwdata_i[PMC_REG_W-1:0];
  assign rb.wstrb = pstrb_i[1:0];
  // Write lands at the edge that samples pready high
  assign rb.wr_en = (cur_ff.st == PMC_ST_RESP) & psel_i & penable_i & pwrite_i & rb.hit;

  // ==========================================================================
  // Answer sequencing
  always_comb begin
    nxt_cur        = cur_ff;
    nxt_cur.ready  = 1'b0;
    nxt_cur.slverr = 1'b0;
    case (cur_ff.st)
      PMC_ST_IDLE: begin
        if (psel_i && penable_i) begin
          nxt_cur.st     = PMC_ST_RESP;
          nxt_cur.ready  = 1'b1;
          nxt_cur.slverr = ~rb.hit;
          nxt_cur.rdata  = (!pwrite_i && rb.hit) ? {16'h0000, rb.rdata} : 32'h0000_0000;
        end
      end
      PMC_ST_RESP: begin
        nxt_cur.st = PMC_ST_IDLE;
      end
      default: begin
        nxt_cur.st = PMC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign prdata_o  = cur_ff.rdata;
  assign pready_o  = cur_ff.ready;
  assign pslverr_o = cur_ff.slverr;

endmodule // pmc_apb_port

/* File: pmc_bank_asserts.sv */
// Purpose: Concurrent checks on the pad mode bank ports
// Assumes: Single clock, async active-high reset
// Notes:   Bound to every instance of the bank
`timescale 1ns/10ps
module pmc_bank_asserts
  import pmc_pkg::*;
(
  input wire logic                   clk_sys_i,
  input wire logic                   reset_i,
  input wire logic                   apb_psel_i,
  input wire logic                   apb_penable_i,
  input wire logic                   apb_pwrite_i,
  input wire logic [17:0]            apb_paddr_i,
  input wire logic [31:0]            apb_pwdata_i,
  input wire logic [3:0]             apb_pstrb_i,
  input wire logic [31:0]            apb_prdata_o,
  input wire logic                   apb_pready_o,
  input wire logic                   apb_pslverr_o,
  input wire logic [15:0]            open_drain_select_p2_o,
  input wire logic [1:0]             level_select_p2_o,
  input wire logic [9:0][3:0][1:0]   nibble_edge_rate_o,
  input wire logic [9:0][3:0][1:0]   nibble_drive_strength_o
);
  import pmc_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  logic        acc;
  logic        wdone;
  logic [15:0] idx;
  assign acc   = apb_psel_i && apb_penable_i;
  assign wdone = apb_pready_o && apb_pwrite_i && acc;
  assign idx   = apb_paddr_i[17:2];

  // ==========================================================================
  // Bus timing
  ready_wait_a: assert property ($rose(acc) |-> !apb_pready_o ##1 apb_pready_o)
    else $error("pready not in second access cycle");
  ready_pulse_a: assert property (apb_pready_o |-> acc ##1 !apb_pready_o)
    else $error("pready outside access or too long");
  err_with_ready_a: assert property (apb_pslverr_o |-> apb_pready_o)
    else $error("pslverr without pready");
  byte_reg_high_a: assert property (apb_pready_o && !apb_pwrite_i && idx == PMC_IDX_PORT4_PAD_DRIVE_CTL
    |-> apb_prdata_o[15:8] == 8'h00) else $error("byte register high byte not zero");

  // ==========================================================================
  // Configuration outputs
  cfg_on_write_a: assert property (!$stable({open_drain_select_p2_o, level_select_p2_o,
    nibble_edge_rate_o, nibble_drive_strength_o}) |-> $past(wdone))
    else $error("configuration changed without write");
  nibble_follow_a: assert property (wdone && idx == PMC_IDX_PORT2_PAD_DRIVE_CTL && apb_pstrb_i[0]
    |=> nibble_edge_rate_o[4][0] == $past(apb_pwdata_i[1:0])
        && nibble_drive_strength_o[4][1] == $past(apb_pwdata_i[7:6]))
    else $error("nibble fields do not follow write");
  od_follow_a: assert property (wdone && idx == PMC_IDX_ODP2 && apb_pstrb_i[1:0] == 2'b11
    |=> open_drain_select_p2_o == $past(apb_pwdata_i[15:0])) else $error("open drain not written");
  level_follow_a: assert property (wdone && idx == PMC_IDX_INPUT_THRESHOLD_SELECT && apb_pstrb_i[0]
    |=> level_select_p2_o == $past(apb_pwdata_i[1:0])) else $error("level select not written");
  upper_nibbles_a: assert property (nibble_edge_rate_o[6][3:2] == 4'h0
    && nibble_drive_strength_o[0][3:2] == 4'h0) else $error("byte register upper nibble set");
endmodule // pmc_bank_asserts

bind pmc_pad_mode_config_bank pmc_bank_asserts u_chk (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .apb_psel_i(apb_psel_i),
  .apb_penable_i(apb_penable_i), .apb_pwrite_i(apb_pwrite_i), .apb_paddr_i(apb_paddr_i),
  .apb_pwdata_i(apb_pwdata_i), .apb_pstrb_i(apb_pstrb_i), .apb_prdata_o(apb_prdata_o),
  .apb_pready_o(apb_pready_o), .apb_pslverr_o(apb_pslverr_o),
  .open_drain_select_p2_o(open_drain_select_p2_o), .level_select_p2_o(level_select_p2_o),
  .nibble_edge_rate_o(nibble_edge_rate_o), .nibble_drive_strength_o(nibble_drive_strength_o));

/* File: pmc_pad_mode_config_bank.sv */
// Purpose: Pad configuration bank: open drain, input threshold, edge and drive
// Assumes: APB master, single 10 MHz clock, async active-high reset
// Notes:   All configuration outputs come straight from register flops
`timescale 1ns/10ps
// Operation
// RL1: one open-drain bit per line, zero push-pull
// RL2: open-drain registers only ports 2,3,4,6,7,8
// RL3: open-drain registers in extended register space
// RL4: threshold bit per port byte
// RL5: low-byte bit selects TTL or hysteresis
// RL6: high-byte bit selects TTL or hysteresis
// RL7: threshold never touches direction or output mode
// RL8: 2-bit edge rate per nibble
// RL9: 2-bit drive strength per nibble
// RL10: edge codes fast, slow, reserved
// RL11: drive codes max, dynamic, reduced, reserved
// RL12: 8-bit port register high byte reads zero
// RL13: 16-bit layout four nibbles, reset zero
// RL14: ten pad registers consecutive F080 to F092
// RL15: outputs follow write next cycle, codes stored raw
module pmc_pad_mode_config_bank
  import pmc_pkg::*;
(
  input  wire logic                            clk_sys_i,
  input  wire logic                            reset_i,
  input  wire logic                            apb_psel_i,
  input  wire logic                            apb_penable_i,
  input  wire logic                            apb_pwrite_i,
  input  wire logic [pmc_pkg::PMC_ADDR_W-1:0]  apb_paddr_i,
  input  wire logic [pmc_pkg::PMC_DATA_W-1:0]  apb_pwdata_i,
  input  wire logic [3:0]                      apb_pstrb_i,
  output logic      [pmc_pkg::PMC_DATA_W-1:0]  apb_prdata_o,
  output logic                                 apb_pready_o,
  output logic                                 apb_pslverr_o,
  output logic      [15:0]                     open_drain_select_p2_o,
  output logic      [15:0]                     open_drain_select_p3_o,
  output logic      [7:0]                      open_drain_select_p4_o,
  output logic      [7:0]                      open_drain_select_p6_o,
  output logic      [7:0]                      open_drain_select_p7_o,
  output logic      [7:0]                      open_drain_select_p8_o,
  output logic      [1:0]                      level_select_p2_o,
  output logic      [1:0]                      level_select_p3_o,
  output logic                                 level_select_p4_o,
  output logic                                 level_select_p7_o,
  output logic                                 level_select_p8_o,
  output logic      [9:0][3:0][1:0]            nibble_edge_rate_o,
  output logic      [9:0][3:0][1:0]            nibble_drive_strength_o
);
  import pmc_pkg::*;

  pmc_regbus_if rb ();

  pmc_word_t            word_val [PMC_SLOTS];
  logic [PMC_SLOTS-1:0] word_wr;
  logic [5:0]           slot_dec;

  // ==========================================================================
  // APB front end
  pmc_apb_port u_apb (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .psel_i    (apb_psel_i),
    .penable_i (apb_penable_i),
    .pwrite_i  (apb_pwrite_i),
    .paddr_i   (apb_paddr_i),
    .pwdata_i  (apb_pwdata_i),
    .pstrb_i   (apb_pstrb_i),
    .prdata_o  (apb_prdata_o),
    .pready_o  (apb_pready_o),
    .pslverr_o (apb_pslverr_o),
    .rb        (rb.front)
  );

  // ==========================================================================
  // Address decode and read mux
  assign slot_dec = pmc_slot_of(rb.index); // RL14 RL3 RL2
  assign rb.hit   = slot_dec[5];

  always_comb begin
    rb.rdata = 16'h0000;
    word_wr  = '0;
    for (int s = 0; s < PMC_SLOTS; s++) begin
      if (rb.hit && (slot_dec[PMC_SLOT_W-1:0] == PMC_SLOT_W'(s))) begin
        rb.rdata   = word_val[s]; // RL12
        word_wr[s] = rb.wr_en;
      end
    end
  end

  // ==========================================================================
  // Storage: pad drive words, open-drain words, threshold word
  for (genvar g = 0; g < PMC_SLOTS; g++) begin : g_word
    pmc_reg_word #(
      .MASK  (pmc_mask_of(g)), // RL12 RL13
      .RESET (PMC_RST_VAL)     // RL1 RL13
    ) u_word (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .wr_en_i   (word_wr[g]),
      .wstrb_i   (rb.wstrb),
      .wdata_i   (rb.wdata),
      .value_o   (word_val[g])
    );
  end

  // ==========================================================================
  // Open-drain selects, one bit per line
  assign open_drain_select_p2_o = word_val[PMC_SLOT_ODP2];       // RL1
  assign open_drain_select_p3_o = word_val[PMC_SLOT_ODP3];       // RL1
  assign open_drain_select_p4_o = word_val[PMC_SLOT_ODP4][7:0];  // RL1
  assign open_drain_select_p6_o = word_val[PMC_SLOT_ODP6][7:0];  // RL1
  assign open_drain_select_p7_o = word_val[PMC_SLOT_ODP7][7:0];  // RL1
  assign open_drain_select_p8_o = word_val[PMC_SLOT_ODP8][7:0];  // RL1

  // ==========================================================================
  // Input thresholds, one bit per byte; only the threshold pads see these
  assign level_select_p2_o = {word_val[PMC_SLOT_INPUT_THRESHOLD_SELECT][PMC_P2HIN],
                              word_val[PMC_SLOT_INPUT_THRESHOLD_SELECT][PMC_P2LIN]}; // RL4 RL5 RL6 RL7
  assign level_select_p3_o = {word_val[PMC_SLOT_INPUT_THRESHOLD_SELECT][PMC_P3HIN],
                              word_val[PMC_SLOT_INPUT_THRESHOLD_SELECT][PMC_P3LIN]}; // RL4 RL5 RL6 RL7
  assign level_select_p4_o = word_val[PMC_SLOT_INPUT_THRESHOLD_SELECT][PMC_P4LIN];   // RL4 RL5
  assign level_select_p7_o = word_val[PMC_SLOT_INPUT_THRESHOLD_SELECT][PMC_P7LIN];   // RL4 RL5
  assign level_select_p8_o = word_val[PMC_SLOT_INPUT_THRESHOLD_SELECT][PMC_P8LIN];   // RL4 RL5

  // ==========================================================================
  // Nibble edge and drive fields, codes passed raw to the pads
  for (genvar r = 0; r < PMC_POCONS; r++) begin : g_pocon
    for (genvar n = 0; n < PMC_NIBS; n++) begin : g_nib
      assign nibble_edge_rate_o[r][n] =
        word_val[r][PMC_NIB_W*n+PMC_EC_LSB +: 2];    // RL8 RL10 RL13
      assign nibble_drive_strength_o[r][n] =
        word_val[r][PMC_NIB_W*n+PMC_DC_LSB +: 2];    // RL9 RL11 RL13
    end
  end

endmodule // pmc_pad_mode_config_bank

/* File: pmc_pkg.sv */
// Purpose: Shared constants, types and decode functions of the pad mode bank
// Assumes: APB with 32-bit data; register index times four is the byte address
// Notes:   Registers are 16 bits wide and sit in the low half of each word
package pmc_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int PMC_ADDR_W = 18;
  localparam int PMC_DATA_W = 32;
  localparam int PMC_REG_W  = 16;
  localparam int PMC_IDX_W  = 16;
  localparam int PMC_SLOTS  = 17;
  localparam int PMC_SLOT_W = 5;
  localparam int PMC_POCONS = 10;
  localparam int PMC_NIBS   = 4;

  // ==========================================================================
  // Register indices (byte address = index * 4)
  localparam logic [15:0] PMC_IDX_PORT0_LOW_PAD_DRIVE_CTL = 16'hF080;
  localparam logic [15:0] PMC_IDX_PORT0_HIGH_PAD_DRIVE_CTL = 16'hF082;
  localparam logic [15:0] PMC_IDX_PORT1_LOW_PAD_DRIVE_CTL = 16'hF084;
  localparam logic [15:0] PMC_IDX_PORT1_HIGH_PAD_DRIVE_CTL = 16'hF086;
  localparam logic [15:0] PMC_IDX_PORT2_PAD_DRIVE_CTL  = 16'hF088;
  localparam logic [15:0] PMC_IDX_PORT3_PAD_DRIVE_CTL  = 16'hF08A;
  localparam logic [15:0] PMC_IDX_PORT4_PAD_DRIVE_CTL  = 16'hF08C;
  localparam logic [15:0] PMC_IDX_PORT6_PAD_DRIVE_CTL  = 16'hF08E;
  localparam logic [15:0] PMC_IDX_PORT7_PAD_DRIVE_CTL  = 16'hF090;
  localparam logic [15:0] PMC_IDX_PORT8_PAD_DRIVE_CTL  = 16'hF092;
  localparam logic [15:0] PMC_IDX_ODP2    = 16'hF0C0;
  localparam logic [15:0] PMC_IDX_ODP3    = 16'hF0C2;
  localparam logic [15:0] PMC_IDX_ODP4    = 16'hF0C4;
  localparam logic [15:0] PMC_IDX_ODP6    = 16'hF0C6;
  localparam logic [15:0] PMC_IDX_ODP7    = 16'hF0C8;
  localparam logic [15:0] PMC_IDX_ODP8    = 16'hF0CA;
  localparam logic [15:0] PMC_IDX_INPUT_THRESHOLD_SELECT   = 16'hF1C4;

  // ==========================================================================
  // Storage slots
  localparam logic [4:0] PMC_SLOT_POCON0 = 5'h00;
  localparam logic [4:0] PMC_SLOT_ODP2   = 5'h0A;
  localparam logic [4:0] PMC_SLOT_ODP3   = 5'h0B;
  localparam logic [4:0] PMC_SLOT_ODP4   = 5'h0C;
  localparam logic [4:0] PMC_SLOT_ODP6   = 5'h0D;
  localparam logic [4:0] PMC_SLOT_ODP7   = 5'h0E;
  localparam logic [4:0] PMC_SLOT_ODP8   = 5'h0F;
  localparam logic [4:0] PMC_SLOT_INPUT_THRESHOLD_SELECT  = 5'h10;

  // ==========================================================================
  // Masks, reset value, field positions
  localparam logic [15:0] PMC_MASK_BYTE  = 16'h00FF;
  localparam logic [15:0] PMC_MASK_WORD  = 16'hFFFF;
  localparam logic [15:0] PMC_MASK_INPUT_THRESHOLD_SELECT = 16'h00DF;
  localparam logic [15:0] PMC_MASK_NONE  = 16'h0000;
  localparam logic [15:0] PMC_RST_VAL    = 16'h0000;
  localparam int PMC_NIB_W  = 4;
  localparam int PMC_EC_LSB = 0;
  localparam int PMC_DC_LSB = 2;
  localparam int PMC_P2LIN  = 0;
  localparam int PMC_P2HIN  = 1;
  localparam int PMC_P3LIN  = 2;
  localparam int PMC_P3HIN  = 3;
  localparam int PMC_P4LIN  = 4;
  localparam int PMC_P7LIN  = 6;
  localparam int PMC_P8LIN  = 7;

  typedef logic [15:0] pmc_word_t;

  typedef enum logic [1:0] {
    PMC_ST_IDLE = 2'b00,
    PMC_ST_RESP = 2'b01
  } pmc_state_t;

  // Index to {hit, slot}
  function automatic logic [5:0] pmc_slot_of(input logic [15:0] idx);
    case (idx)
      PMC_IDX_PORT0_LOW_PAD_DRIVE_CTL: pmc_slot_of = 6'h20;
      PMC_IDX_PORT0_HIGH_PAD_DRIVE_CTL: pmc_slot_of = 6'h21;
      PMC_IDX_PORT1_LOW_PAD_DRIVE_CTL: pmc_slot_of = 6'h22;
      PMC_IDX_PORT1_HIGH_PAD_DRIVE_CTL: pmc_slot_of = 6'h23;
      PMC_IDX_PORT2_PAD_DRIVE_CTL:  pmc_slot_of = 6'h24;
      PMC_IDX_PORT3_PAD_DRIVE_CTL:  pmc_slot_of = 6'h25;
      PMC_IDX_PORT4_PAD_DRIVE_CTL:  pmc_slot_of = 6'h26;
      PMC_IDX_PORT6_PAD_DRIVE_CTL:  pmc_slot_of = 6'h27;
      PMC_IDX_PORT7_PAD_DRIVE_CTL:  pmc_slot_of = 6'h28;
      PMC_IDX_PORT8_PAD_DRIVE_CTL:  pmc_slot_of = 6'h29;
      PMC_IDX_ODP2:    pmc_slot_of = {1'b1, PMC_SLOT_ODP2};
      PMC_IDX_ODP3:    pmc_slot_of = {1'b1, PMC_SLOT_ODP3};
      PMC_IDX_ODP4:    pmc_slot_of = {1'b1, PMC_SLOT_ODP4};
      PMC_IDX_ODP6:    pmc_slot_of = {1'b1, PMC_SLOT_ODP6};
      PMC_IDX_ODP7:    pmc_slot_of = {1'b1, PMC_SLOT_ODP7};
      PMC_IDX_ODP8:    pmc_slot_of = {1'b1, PMC_SLOT_ODP8};
      PMC_IDX_INPUT_THRESHOLD_SELECT:   pmc_slot_of = {1'b1, PMC_SLOT_INPUT_THRESHOLD_SELECT};
      default:         pmc_slot_of = 6'h00;
    endcase
  endfunction

  // Implemented bits of each slot
  function automatic logic [15:0] pmc_mask_of(input int slot);
    case (slot)
      4, 5, 10, 11: pmc_mask_of = PMC_MASK_WORD;
      16:           pmc_mask_of = PMC_MASK_INPUT_THRESHOLD_SELECT;
      default:      pmc_mask_of = (slot < PMC_SLOTS) ? PMC_MASK_BYTE : PMC_MASK_NONE;
    endcase
  endfunction

endpackage

/* File: pmc_reg_word.sv */
// Purpose: One configuration word with byte-lane writes and a fixed bit mask
// Assumes: Write enable is already qualified by address decode
// Notes:   Unimplemented bits stay at zero and read as zero
`timescale 1ns/10ps
module pmc_reg_word
  import pmc_pkg::*;
#(
  parameter logic [15:0] MASK  = 16'hFFFF,
  parameter logic [15:0] RESET = 16'h0000
) (
  input  wire logic                           clk_sys_i,
  input  wire logic                           reset_i,
  input  wire logic                           wr_en_i,
  input  wire logic [1:0]                     wstrb_i,
  input  wire logic [pmc_pkg::PMC_REG_W-1:0]  wdata_i,
  output logic      [pmc_pkg::PMC_REG_W-1:0]  value_o
);
  import pmc_pkg::*;

  typedef struct packed {
    pmc_word_t value;
  } pmc_word_state_t;

  pmc_word_state_t cur_ff;
  pmc_word_state_t nxt_cur;
  pmc_word_t       lanes;

  // Reserved codes kept as written
  always_comb begin
    lanes   = {{8{wstrb_i[1]}}, {8{wstrb_i[0]}}} & MASK;
    nxt_cur = cur_ff;
    if (wr_en_i) begin
      nxt_cur.value = (cur_ff.value & ~lanes) | (wdata_i & lanes); // RL15
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cur_ff.value <= RESET & MASK;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign value_o = cur_ff.value;

endmodule // pmc_reg_word

/* File: pmc_regbus_if.sv */
// Purpose: Carrier between the APB front end and the register storage
// Assumes: Single clock domain
// Notes:   Index is the word index taken from the APB address
`timescale 1ns/10ps
interface pmc_regbus_if;
  logic        wr_en;
  logic [15:0] index;
  logic [15:0] wdata;
  logic [1:0]  wstrb;
  logic [15:0] rdata;
  logic        hit;

  modport front (output wr_en, index, wdata, wstrb, input rdata, hit);
  modport bank  (input wr_en, index, wdata, wstrb, output rdata, hit);
endinterface

/* File: tb.sv */
// Purpose: Directed test of the pad mode bank over APB
// Assumes: Byte address is four times the register index
// Notes:   A shadow copy of every register gives the expectations
`timescale 1ns/10ps
module tb;
  import pmc_pkg::*;
  logic                 clk_sys_i, reset_i, psel, pen, pwr, pready, perr, rd_e;
  logic [17:0]          paddr;
  logic [31:0]          pwdata, prdata, rd_v;
  logic [3:0]           pstrb;
  logic [15:0]          od2, od3;
  logic [7:0]           od4, od6, od7, od8;
  logic [1:0]           lv2, lv3;
  logic                 lv4, lv7, lv8;
  logic [9:0][3:0][1:0] ner, nds;
  logic [15:0]          allx [17];
  logic [15:0]          mk [17];
  logic [15:0]          ev [17];
  int                   n_mismatch, checks, i;

  pmc_pad_mode_config_bank u_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .apb_psel_i(psel),
    .apb_penable_i(pen), .apb_pwrite_i(pwr), .apb_paddr_i(paddr), .apb_pwdata_i(pwdata),
    .apb_pstrb_i(pstrb), .apb_prdata_o(prdata), .apb_pready_o(pready), .apb_pslverr_o(perr),
    .open_drain_select_p2_o(od2), .open_drain_select_p3_o(od3), .open_drain_select_p4_o(od4),
    .open_drain_select_p6_o(od6), .open_drain_select_p7_o(od7), .open_drain_select_p8_o(od8),
    .level_select_p2_o(lv2), .level_select_p3_o(lv3), .level_select_p4_o(lv4),
    .level_select_p7_o(lv7), .level_select_p8_o(lv8), .nibble_edge_rate_o(ner),
    .nibble_drive_strength_o(nds));

  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // ==========================================================================
  // Shared tasks
  task automatic give_verdict();
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [79:0] seen, input logic [79:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] idx, input logic [15:0] d, input logic [3:0] s);
    int k;
    @(posedge clk_sys_i);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= {idx, 2'b00};
    pwdata <= {~d, d};
    pstrb  <= s;
    @(posedge clk_sys_i);
    pen <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_sys_i);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      n_mismatch++;
      give_verdict();
    end
    rd_v = prdata;
    rd_e = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic wr(input int r, input logic [15:0] d, input logic [3:0] s);
    apb(1'b1, allx[r], d, s);
    if (s[0]) ev[r][7:0] = d[7:0];
    if (s[1]) ev[r][15:8] = d[15:8];
    ev[r] &= mk[r];
  endtask

  task automatic rd(input int r);
    apb(1'b0, allx[r], 16'h0000, 4'h0);
    chk("rdata", rd_v, {16'h0000, ev[r]});
    chk("rd_err", rd_e, 1'b0);
  endtask

  task automatic outs();
    int r, n;
    chk("od", {od2, od3, od4, od6, od7, od8}, {ev[10], ev[11], ev[12][7:0], ev[13][7:0],
      ev[14][7:0], ev[15][7:0]});
    chk("lvl", {lv2, lv3, lv4, lv7, lv8}, {ev[16][1:0], ev[16][3:2], ev[16][4], ev[16][6], ev[16][7]});
    for (r = 0; r < 10; r++) begin
      for (n = 0; n < 4; n++) begin
        chk("edge", ner[r][n], ev[r][4*n+:2]);
        chk("drive", nds[r][n], ev[r][4*n+2+:2]);
      end
    end
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_power_up();
    int r;
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    outs();
    for (r = 0; r < 17; r++) rd(r);
  endtask

  task automatic t_all(input logic [15:0] base, input int lo, input int hi);
    int r;
    for (r = lo; r < hi; r++) wr(r, base ^ {2{r[7:0]}}, 4'hF);
    for (r = lo; r < hi; r++) rd(r);
    outs();
  endtask

  task automatic t_lanes();
    wr(5, 16'h1234, 4'b0010);
    wr(12, 16'hFFFF, 4'b0001);
    wr(4, 16'hFFFF, 4'b0100);
    rd(5);
    rd(12);
    rd(4);
    outs();
  endtask

  task automatic t_thresh();
    wr(16, 16'hFFFF, 4'hF);
    rd(16);
    outs();
    wr(16, 16'h0055, 4'h1);
    rd(16);
    outs();
  endtask

  task automatic t_unmapped();
    apb(1'b1, 16'hF094, 16'hFFFF, 4'hF);
    chk("wr_err", rd_e, 1'b1);
    apb(1'b0, 16'hF094, 16'h0000, 4'h0);
    chk("rd_err", {rd_e, rd_v}, {1'b1, 32'h0000_0000});
    apb(1'b1, 16'hF0CC, 16'hFFFF, 4'hF);
    rd(9);
    outs();
  endtask

  task automatic t_reset();
    int r;
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    ev = '{default: 16'h0000};
    outs();
    for (r = 0; r < 17; r++) rd(r);
  endtask

  initial begin
    reset_i = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    n_mismatch = 0;
    checks = 0;
    allx = '{PMC_IDX_PORT0_LOW_PAD_DRIVE_CTL, PMC_IDX_PORT0_HIGH_PAD_DRIVE_CTL, PMC_IDX_PORT1_LOW_PAD_DRIVE_CTL, PMC_IDX_PORT1_HIGH_PAD_DRIVE_CTL, PMC_IDX_PORT2_PAD_DRIVE_CTL,
      PMC_IDX_PORT3_PAD_DRIVE_CTL, PMC_IDX_PORT4_PAD_DRIVE_CTL, PMC_IDX_PORT6_PAD_DRIVE_CTL, PMC_IDX_PORT7_PAD_DRIVE_CTL, PMC_IDX_PORT8_PAD_DRIVE_CTL, PMC_IDX_ODP2,
      PMC_IDX_ODP3, PMC_IDX_ODP4, PMC_IDX_ODP6, PMC_IDX_ODP7, PMC_IDX_ODP8, PMC_IDX_INPUT_THRESHOLD_SELECT};
    mk = '{default: 16'h00FF};
    for (i = 4; i < 12; i++) if (i == 4 || i == 5 || i >= 10) mk[i] = 16'hFFFF;
    mk[16] = 16'h00DF;
    ev = '{default: 16'h0000};
    t_power_up();
    t_all(16'hFA50, 0, 10);
    t_all(16'hC3A5, 10, 16);
    t_lanes();
    t_thresh();
    t_unmapped();
    t_reset();
    give_verdict();
  end
endmodule // tb
